// ===== rtl/fpr_defines.vh
// Constants for the fan drive ramp smoothing control block.
// Assumes inclusion by bare name; definitions only, no logic.
`ifndef FPR_DEFINES_VH
`define FPR_DEFINES_VH

// Register offsets
`define FPR_OFS_CONFIG_ONE   8'h62
`define FPR_OFS_CONFIG_TWO   8'h63

// Reset values
`define FPR_RST_CONFIG_ONE   8'h00
`define FPR_RST_CONFIG_TWO   8'h00

// Field positions within acoustic_ramp_config_one
`define FPR_FLD_RATE_HI      2
`define FPR_FLD_RATE_LO      0
`define FPR_BIT_SMOOTH_ON    3
`define FPR_BIT_TACH_SYNC    4
`define FPR_BIT_FLOOR1       5
`define FPR_BIT_FLOOR2       6
`define FPR_BIT_FLOOR3       7

// Time slot increments for ramp codes 000..111
`define FPR_INC_0            6'h01
`define FPR_INC_1            6'h02
`define FPR_INC_2            6'h03
`define FPR_INC_3            6'h04
`define FPR_INC_4            6'h08
`define FPR_INC_5            6'h0c
`define FPR_INC_6            6'h18
`define FPR_INC_7            6'h30

// Full scale ramp time at increment one, in milliseconds
`define FPR_FULL_FAST_MS     37500
`define FPR_FULL_SLOW_MS     52200
// Clock cycles per millisecond at 25 MHz
`define FPR_CYC_PER_MS       25000
// Duty steps from 0% to 100%
`define FPR_FULL_SCALE       255
// Further slow-down factor as a shift (factor of four)
`define FPR_SLOWDOWN_SHIFT   2

`endif

// ===== rtl/fpr_ramp_ctrl.v
// Fan drive ramp smoothing control: enhanced-acoustics config registers,
// slot timer, first drive ramp, floor selection and tach sync select.
// Assumes a simple same-clock register port and same-clock duty inputs
// from the automatic fan loop; lock and config-six bits arrive as levels.
`timescale 1ns/1ns
`include "fpr_defines.vh"

module fpr_ramp_ctrl #(
    parameter WIDTH = 8,                // Duty width
    // Cycles per time slot at increment one, fast and slow tables
    parameter [31:0] SLOT_FAST_CYC =
        (`FPR_FULL_FAST_MS * `FPR_CYC_PER_MS) / `FPR_FULL_SCALE,
    parameter [31:0] SLOT_SLOW_CYC =
        (`FPR_FULL_SLOW_MS * `FPR_CYC_PER_MS) / `FPR_FULL_SCALE
) (
    // Clock and reset
    input  wire             core_clk_in,
    input  wire             rst_n_in,
    // Register port
    input  wire [7:0]       reg_addr_in,      // Register offset
    input  wire             reg_wr_in,        // Write strobe
    input  wire [7:0]       reg_wdata_in,     // Write data
    output reg  [7:0]       reg_rdata_out,    // Read data, one cycle late
    // Loose configuration bits held elsewhere
    input  wire             cfg_lock_in,      // Global lock
    input  wire             slow_ramp_sel_in, // Slow ramp table select
    input  wire             ramp_slowdown_in, // Further divide by four
    // Automatic loop inputs
    input  wire [2:0]       auto_mode_in,     // Per-drive automatic mode
    input  wire [2:0]       below_min_in,     // Temp under threshold-hyst
    input  wire [WIDTH-1:0] duty1_in,         // Computed duty, drive one
    input  wire [WIDTH-1:0] duty2_in,         // Computed duty, drive two
    input  wire [WIDTH-1:0] duty3_in,         // Computed duty, drive three
    input  wire [WIDTH-1:0] floor_duty1_in,   // Minimum duty, drive one
    input  wire [WIDTH-1:0] floor_duty2_in,   // Minimum duty, drive two
    input  wire [WIDTH-1:0] floor_duty3_in,   // Minimum duty, drive three
    // Outputs to the duty generators and tach logic
    output wire [WIDTH-1:0] fan_drive_1_out,  // Applied duty, drive one
    output reg  [WIDTH-1:0] fan_drive_2_out,  // Applied duty, drive two
    output reg  [WIDTH-1:0] fan_drive_3_out,  // Applied duty, drive three
    output reg  [2:0]       speed_sync_out    // Inputs 3,4 synced to d3; input 2 when sync-all set
);

    // Register storage
    // Both registers share the write strobe; only the first has fields
    reg  [7:0]  acoustic_ramp_config_one;  // Ramp, smoothing, sync, floors
    reg  [7:0]  acoustic_ramp_config_two;  // Kept for software, no logic

    // Field views
    wire [2:0]  remote1_ramp_rate =
        acoustic_ramp_config_one[`FPR_FLD_RATE_HI:`FPR_FLD_RATE_LO];
    wire        remote1_smoothing_on =
        acoustic_ramp_config_one[`FPR_BIT_SMOOTH_ON];
    wire        tach_sync_all =
        acoustic_ramp_config_one[`FPR_BIT_TACH_SYNC];
    wire        drive1_floor_select =
        acoustic_ramp_config_one[`FPR_BIT_FLOOR1];
    wire        drive2_floor_select =
        acoustic_ramp_config_one[`FPR_BIT_FLOOR2];
    wire        drive3_floor_select =
        acoustic_ramp_config_one[`FPR_BIT_FLOOR3];

    // Slot timer
    reg  [33:0] slot_cnt;                  // Cycles into current slot
    reg  [33:0] slot_len;                  // Length of a slot in cycles
    wire        slot_tick;                 // One-cycle slot pulse

    // Targets after floor handling
    reg  [WIDTH-1:0] target1;
    reg  [WIDTH-1:0] next_drive_2;
    reg  [WIDTH-1:0] next_drive_3;
    reg  [5:0]       ramp_inc;             // Increment for this code

    // Register writes; a locked register silently drops writes.
    // No error is flagged, so software must read back to notice.
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acoustic_ramp_config_one <= `FPR_RST_CONFIG_ONE;
            acoustic_ramp_config_two <= `FPR_RST_CONFIG_TWO;
        end else if (reg_wr_in && !cfg_lock_in) begin
            if (reg_addr_in == `FPR_OFS_CONFIG_ONE) begin
                acoustic_ramp_config_one <= reg_wdata_in;
            end else if (reg_addr_in == `FPR_OFS_CONFIG_TWO) begin
                acoustic_ramp_config_two <= reg_wdata_in;
            end
        end
    end

    // Registered read; unmapped offsets read zero.
    // Decoded every cycle, so software may poll without a strobe.
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_addr_in == `FPR_OFS_CONFIG_ONE) begin
            reg_rdata_out <= acoustic_ramp_config_one;
        end else if (reg_addr_in == `FPR_OFS_CONFIG_TWO) begin
            reg_rdata_out <= acoustic_ramp_config_two;
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // Increment per slot from the ramp code; both tables share it
    always @* begin
        case (remote1_ramp_rate)
            3'h0:    ramp_inc = `FPR_INC_0;
            3'h1:    ramp_inc = `FPR_INC_1;
            3'h2:    ramp_inc = `FPR_INC_2;
            3'h3:    ramp_inc = `FPR_INC_3;
            3'h4:    ramp_inc = `FPR_INC_4;
            3'h5:    ramp_inc = `FPR_INC_5;
            3'h6:    ramp_inc = `FPR_INC_6;
            default: ramp_inc = `FPR_INC_7;
        endcase
    end

    // Slot length: the slow table stretches the slot, slow-down by four.
    // Full-scale times per code follow from 255 / increment slots, so
    // the shorter codes land within rounding of the nominal figures.
    always @* begin
        if (slow_ramp_sel_in)
            slot_len = {2'b00, SLOT_SLOW_CYC};
        else
            slot_len = {2'b00, SLOT_FAST_CYC};
        if (ramp_slowdown_in)
            slot_len = slot_len << `FPR_SLOWDOWN_SHIFT;
    end

    assign slot_tick = (slot_cnt + 34'h1 >= slot_len);

    // Free-running slot counter; restarts if the length shrinks to slot_cnt + 1 or less.
    // Shared by every code, so a new code takes hold at the next slot
    // boundary instead of restarting the slot in progress.
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            slot_cnt <= 34'h0;
        else if (slot_tick)
            slot_cnt <= 34'h0;
        else
            slot_cnt <= slot_cnt + 34'h1;
    end

    // Drive one target: floor choice below threshold in auto mode.
    // Floor logic sits ahead of the ramp, so the drop to zero or to
    // the minimum is smoothed as well while smoothing is on.
    always @* begin
        target1 = duty1_in;
        if (auto_mode_in[0] && below_min_in[0]) begin
            if (drive1_floor_select)
                target1 = floor_duty1_in;
            else
                target1 = {WIDTH{1'b0}};
        end
    end

    // Drive one ramps toward its target at the selected rate
    fpr_ramp_step #(
        .WIDTH     (WIDTH),
        .INC_W     (6)
    ) u_ramp1 (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .smooth_in   (remote1_smoothing_on),
        .step_in     (slot_tick),
        .inc_in      (ramp_inc),
        .target_in   (target1),
        .duty_out    (fan_drive_1_out)
    );

    // Drives two and three: floor choice, then applied at once
    always @* begin
        next_drive_2 = duty2_in;
        next_drive_3 = duty3_in;
        if (auto_mode_in[1] && below_min_in[1]) begin
            if (drive2_floor_select)
                next_drive_2 = floor_duty2_in;
            else
                next_drive_2 = {WIDTH{1'b0}};
        end
        if (auto_mode_in[2] && below_min_in[2]) begin
            if (drive3_floor_select)
                next_drive_3 = floor_duty3_in;
            else
                next_drive_3 = {WIDTH{1'b0}};
        end
    end

    // Registered duties for drives two and three
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fan_drive_2_out <= {WIDTH{1'b0}};
            fan_drive_3_out <= {WIDTH{1'b0}};
        end else begin
            fan_drive_2_out <= next_drive_2;
            fan_drive_3_out <= next_drive_3;
        end
    end

    // Tach sync: input two joins only when sync-all is set.
    // Inputs three and four always follow drive three; the bit only
    // decides whether input two is measured against it as well.
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            speed_sync_out <= 3'b000;
        else
            speed_sync_out <= {2'b11, tach_sync_all};
    end

endmodule // fpr_ramp_ctrl

// ===== rtl/fpr_ramp_step.v
// One duty-cycle ramp stage: moves a duty value toward its target.
// Assumes step_in is a one-cycle pulse on the same clock.
`timescale 1ns/1ns

module fpr_ramp_step #(
    parameter WIDTH = 8,                // Duty width
    parameter INC_W = 6                 // Increment width
) (
    // Clock and reset
    input  wire             core_clk_in,
    input  wire             rst_n_in,
    // Control
    input  wire             smooth_in,  // Ramp when high, jump when low
    input  wire             step_in,    // Time slot tick
    input  wire [INC_W-1:0] inc_in,     // Per-slot increment
    input  wire [WIDTH-1:0] target_in,  // Wanted duty
    // Result
    output reg  [WIDTH-1:0] duty_out    // Applied duty
);

    // Widened increment so the compares below never wrap
    wire [WIDTH:0] inc_w = {{(WIDTH+1-INC_W){1'b0}}, inc_in};
    wire [WIDTH:0] diff_up = {1'b0, target_in} - {1'b0, duty_out};
    wire [WIDTH:0] diff_dn = {1'b0, duty_out} - {1'b0, target_in};
    reg  [WIDTH-1:0] next_duty;

    // Next duty: jump, step, or land on target when close
    always @* begin
        next_duty = duty_out;
        if (!smooth_in) begin
            next_duty = target_in;
        end else if (step_in) begin
            if (target_in > duty_out) begin
                // Clamp so the ramp never overshoots
                if (diff_up <= inc_w)
                    next_duty = target_in;
                else
                    next_duty = duty_out + inc_w[WIDTH-1:0];
            end else if (target_in < duty_out) begin
                if (diff_dn <= inc_w)
                    next_duty = target_in;
                else
                    next_duty = duty_out - inc_w[WIDTH-1:0];
            end
        end
    end

    // Duty register
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            duty_out <= {WIDTH{1'b0}};
        else
            duty_out <= next_duty;
    end

endmodule // fpr_ramp_step

// ===== testbench/fpr_fan_model.sv
// Behavioural fans hung on the three drive outputs.
// Assumes duty values settle on the controller clock.
`timescale 1ns/1ns
module fpr_fan_model (
    // Duty from the controller
    input  wire [7:0] fan_drive_1_in,
    input  wire [7:0] fan_drive_2_in,
    input  wire [7:0] fan_drive_3_in,
    // One bit a fan, high while turning
    output wire [2:0] spinning_out
);
    // Crude: any nonzero duty spins, no stall threshold modelled
    assign spinning_out = {fan_drive_3_in != 8'h00,
                           fan_drive_2_in != 8'h00,
                           fan_drive_1_in != 8'h00};
endmodule // fpr_fan_model

// ===== testbench/fpr_ramp_ctrl_properties.sv
// Port checker for the ramp smoothing control block.
// Assumes binding into fpr_ramp_ctrl; shadows register 0x62 itself.
`timescale 1ns/1ns
module fpr_ramp_ctrl_properties (
    // Clock, reset and register port
    input wire       core_clk_in,
    input wire       rst_n_in,
    input wire [7:0] reg_addr_in,
    input wire       reg_wr_in,
    input wire [7:0] reg_wdata_in,
    input wire [7:0] reg_rdata_out,
    input wire       cfg_lock_in,
    // Automatic loop and drives
    input wire [2:0] auto_mode_in,
    input wire [2:0] below_min_in,
    input wire [7:0] duty1_in,
    input wire [7:0] duty2_in,
    input wire [7:0] duty3_in,
    input wire [7:0] floor_duty1_in,
    input wire [7:0] floor_duty2_in,
    input wire [7:0] floor_duty3_in,
    input wire [7:0] fan_drive_1_out,
    input wire [7:0] fan_drive_2_out,
    input wire [7:0] fan_drive_3_out,
    input wire [2:0] speed_sync_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    reg  [7:0] cfg_q; // Shadow of the fields register
    // Shadow honours the lock, so a leaky lock shows on read-back
    always @(posedge core_clk_in or negedge rst_n_in)
        if (!rst_n_in) cfg_q <= 8'h00;
        else if (reg_wr_in && !cfg_lock_in && reg_addr_in == 8'h62)
            cfg_q <= reg_wdata_in;
    // Per-drive targets after floor selection
    wire [7:0] tgt1 = (auto_mode_in[0] && below_min_in[0]) ?
                      (cfg_q[5] ? floor_duty1_in : 8'h00) : duty1_in;
    wire [7:0] tgt2 = (auto_mode_in[1] && below_min_in[1]) ?
                      (cfg_q[6] ? floor_duty2_in : 8'h00) : duty2_in;
    wire [7:0] tgt3 = (auto_mode_in[2] && below_min_in[2]) ?
                      (cfg_q[7] ? floor_duty3_in : 8'h00) : duty3_in;
    // Largest step allowed per slot for the current code
    wire [7:0] step = cfg_q[2] ?
        (cfg_q[1] ? (cfg_q[0] ? 8'h30 : 8'h18) : (cfg_q[0] ? 8'h0c : 8'h08))
        : {6'h00, cfg_q[1:0]} + 8'h01;
    chk_sync_select: assert property (1'b1 |=>
        speed_sync_out == {2'b11, $past(cfg_q[4])})
        else $error("speed sync select wrong");
    chk_read_back: assert property (reg_addr_in == 8'h62 |=>
        reg_rdata_out == $past(cfg_q)) else $error("fields read back wrong");
    chk_unmapped_zero: assert property ((reg_addr_in != 8'h62 &&
        reg_addr_in != 8'h63) |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    chk_lock_frozen: assert property ((cfg_lock_in &&
        $past(cfg_lock_in) && $stable(reg_addr_in)) |=> $stable(reg_rdata_out))
        else $error("locked register changed");
    chk_drive1_jump: assert property (!cfg_q[3] |=>
        fan_drive_1_out == $past(tgt1)) else $error("drive one did not jump");
    chk_drive2_target: assert property (1'b1 |=>
        fan_drive_2_out == $past(tgt2)) else $error("drive two wrong");
    chk_drive3_target: assert property (1'b1 |=>
        fan_drive_3_out == $past(tgt3)) else $error("drive three wrong");
    chk_ramp_slew: assert property (cfg_q[3] |=>
        ((fan_drive_1_out >= $past(fan_drive_1_out)) ?
        fan_drive_1_out - $past(fan_drive_1_out) :
        $past(fan_drive_1_out) - fan_drive_1_out) <= $past(step))
        else $error("drive one moved faster than its ramp step");
endmodule // fpr_ramp_ctrl_properties

bind fpr_ramp_ctrl fpr_ramp_ctrl_properties u_props (.core_clk_in,
    .rst_n_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rdata_out,
    .cfg_lock_in, .auto_mode_in, .below_min_in, .duty1_in, .duty2_in,
    .duty3_in, .floor_duty1_in, .floor_duty2_in, .floor_duty3_in,
    .fan_drive_1_out, .fan_drive_2_out, .fan_drive_3_out, .speed_sync_out);

// ===== testbench/test_fan_pwm_ramp_smoothing_control.sv
// Self-checking bench for the ramp smoothing control block.
// Assumes short slot parameters so full ramps finish quickly.
`timescale 1ns/1ns
module test_fan_pwm_ramp_smoothing_control;
    reg        clk = 1'b0, rst_n = 1'b0, wr = 1'b0;   // Clock, reset, strobe
    reg        lock = 1'b0, slow = 1'b0, sd = 1'b0;   // Loose config bits
    reg  [7:0] addr = 8'h00, wdata = 8'h00;           // Register port
    reg  [2:0] auto_m = 3'h0, below = 3'h0;           // Loop state
    reg  [7:0] d1 = 8'h00, d2 = 8'h11, d3 = 8'h22;    // Computed duties
    reg  [7:0] m1 = 8'h21, m2 = 8'h42, m3 = 8'h63;    // Minimum duties
    wire [7:0] rdata, f1, f2, f3;                     // Outputs
    wire [2:0] sync, spin;                            // Sync and fan state
    integer    mismatches = 0, n_tests = 0, i, j, n, len;
    // Rows: {slowdown, slow table, code, slots to full scale}
    reg [13:0] rows [0:12] = '{14'h00ff, 14'h0280, 14'h0455, 14'h0640,
        14'h0820, 14'h0a16, 14'h0c0b, 14'h0e06, 14'h10ff, 14'h1a16,
        14'h1e06, 14'h2e06, 14'h3a16};
    fpr_ramp_ctrl #(.SLOT_FAST_CYC(32'h4), .SLOT_SLOW_CYC(32'h6)) DUT (
        .core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .cfg_lock_in(lock), .slow_ramp_sel_in(slow), .ramp_slowdown_in(sd),
        .auto_mode_in(auto_m), .below_min_in(below), .duty1_in(d1),
        .duty2_in(d2), .duty3_in(d3), .floor_duty1_in(m1),
        .floor_duty2_in(m2), .floor_duty3_in(m3), .fan_drive_1_out(f1),
        .fan_drive_2_out(f2), .fan_drive_3_out(f3), .speed_sync_out(sync));
    fpr_fan_model u_fans (.fan_drive_1_in(f1), .fan_drive_2_in(f2),
        .fan_drive_3_in(f3), .spinning_out(spin));
    always #20 clk = ~clk; // 25 MHz
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Write, then idle a cycle so the strobe never re-rises in one step
    task wr_reg(input [7:0] a, input [7:0] v);
        begin
            addr = a;
            wdata = v;
            wr = 1'b1;
            @(negedge clk);
            wr = 1'b0;
            @(negedge clk);
        end
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        begin
            addr = a;
            @(negedge clk);
            check(rdata, exp);
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // Watchdog, well past the expected few thousand cycles
    initial begin
        #(20000 * 40);
        mismatches = mismatches + 1;
        report_and_stop;
    end
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        for (i = 0; i < 13; i = i + 1) begin
            {sd, slow} = rows[i][13:12];
            wr_reg(8'h62, 8'h00); // Smoothing off, drop to zero
            d1 = 8'h00;
            repeat (2) @(negedge clk);
            wr_reg(8'h62, {5'h01, rows[i][11:9]});
            d1 = 8'hff;
            n = 0;
            while (f1 !== 8'hff && n < 5000) begin
                @(negedge clk);
                n = n + 1;
            end
            len = (slow ? 6 : 4) << (sd ? 2 : 0);
            check(f1, 8'hff);
            check(n > (rows[i][8:0] - 1) * len && n <= rows[i][8:0] * len + 2,
                  1'h1);
            $display("ramp row %0d done after %0d cycles", i, n);
        end
        // Ramp back down at the last row's rate, slew must still hold
        d1 = 8'h00;
        n = 0;
        while (f1 !== 8'h00 && n < 5000) begin
            @(negedge clk);
            n = n + 1;
        end
        check(f1, 8'h00);
        check(n > (rows[12][8:0] - 1) * len && n <= rows[12][8:0] * len + 2,
              1'h1);
        $display("down ramp done after %0d cycles", n);
        // Reset values and plain storage
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        rd(8'h62, 8'h00);
        check(sync, 3'h6);
        wr_reg(8'h63, 8'ha5);
        rd(8'h63, 8'ha5);
        rd(8'h7f, 8'h00);
        $display("reset test done");
        // Writes refused while locked
        lock = 1'b1;
        wr_reg(8'h62, 8'hff);
        wr_reg(8'h63, 8'h00);
        rd(8'h62, 8'h00);
        rd(8'h63, 8'ha5);
        lock = 1'b0;
        $display("lock test done");
        // Every floor choice, sync bit riding on bit five's value
        {auto_m, below, d1, d2, d3} = {6'h3f, 24'h808080};
        for (j = 0; j < 8; j = j + 1) begin
            wr_reg(8'h62, {j[2:0], j[0], 4'h0});
            check(f1, j[0] ? m1 : 8'h00);
            check(f2, j[1] ? m2 : 8'h00);
            check(f3, j[2] ? m3 : 8'h00);
            check(sync, {2'b11, j[0]});
            check(spin, j[2:0]);
        end
        below = 3'h0;
        @(negedge clk);
        check(f1, 8'h80);
        check(f3, 8'h80);
        // Below threshold with automatic mode off: floors must not apply
        auto_m = 3'h0;
        below = 3'h7;
        @(negedge clk);
        check(f1, 8'h80);
        check(f2, 8'h80);
        check(f3, 8'h80);
        $display("floor test done");
        report_and_stop;
    end
endmodule // test_fan_pwm_ramp_smoothing_control
